// ==== core/speed_case_selector.sv ====
// Wheel speed measurement, channel cross-check and monitoring case selection.
// Assumes pulse and direction inputs already synchronous to clk_sys_i, one pulse per high cycle.
`default_nettype none
module speed_case_selector #(
  parameter int unsigned NUM_CASES = speed_case_pkg::NUM_CASES,
  parameter int unsigned GATE_CYC = speed_case_pkg::GATE_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic inc_enable_i,
  input wire logic [3:0] gen_in_i,
  input wire logic wheel_pulse_first_dir_i,
  input wire logic wheel_pulse_second_dir_i,
  input wire logic [speed_case_pkg::PPC_W-1:0] ppc_first_i,
  input wire logic [speed_case_pkg::PPC_W-1:0] ppc_second_i,
  input wire logic [6:0] diff_pct_i,
  input wire logic [NUM_CASES-1:0] case_valid_i,
  input wire logic [NUM_CASES-1:0] case_use_speed_i,
  input wire logic [NUM_CASES-1:0] case_in_a_i,
  input wire logic [NUM_CASES*speed_case_pkg::SPEED_W-1:0] case_min_i,
  input wire logic [NUM_CASES*speed_case_pkg::SPEED_W-1:0] case_max_i,
  input wire logic [NUM_CASES-1:0] case_out_b_i,
  input wire logic [NUM_CASES-1:0] field_clear_i,
  input wire logic [1:0] restart_delayed_i,
  input wire logic [1:0] sensors_present_i,
  output logic [1:0] gen_in_o,
  output logic signed [speed_case_pkg::SPEED_W-1:0] speed_o,
  output logic [NUM_CASES-1:0] case_active_o,
  output logic safety_output_a_o,
  output logic safety_output_b_o,
  output logic diff_flag_o,
  output logic error_o
);
  localparam int unsigned SW = speed_case_pkg::SPEED_W;
  typedef logic signed [SW-1:0] speed_t;

  // Refuse parameter values that the counters and the selection cannot serve.
  if (NUM_CASES < 2 || NUM_CASES > 16 || GATE_CYC < 2) begin : g_bad_params
    $error("speed_case_selector: bad parameters");
  end

  // [RULE1] Inputs C and D reserved for pulses.
  wire pulse_first = inc_enable_i & gen_in_i[2];
  wire pulse_second = inc_enable_i & gen_in_i[3];

  logic [31:0] gate_cnt_reg;
  logic [15:0] cnt_first_reg, cnt_second_reg;
  speed_t spd_first_reg, spd_second_reg;
  logic dir_first_reg, dir_second_reg, gate_tick_reg;
  wire gate_end = gate_cnt_reg == GATE_CYC - 1;

  // Pulses counted over a fixed gate; each count becomes cm/s.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gate_cnt_reg <= 32'h0;
      cnt_first_reg <= 16'h0;
      cnt_second_reg <= 16'h0;
      gate_tick_reg <= 1'b0;
    end else begin
      gate_cnt_reg <= gate_end ? 32'h0 : gate_cnt_reg + 32'h1;
      cnt_first_reg <= gate_end ? 16'h0 : cnt_first_reg + {15'h0, pulse_first};
      cnt_second_reg <= gate_end ? 16'h0 : cnt_second_reg + {15'h0, pulse_second};
      gate_tick_reg <= gate_end;
    end
  end

  // [RULE2] Count divided by pulses-per-cm, scaled to cm/s.
  function automatic speed_t to_speed(input logic [15:0] cnt, input logic [7:0] ppc, input logic rev);
    logic [31:0] cms;
    speed_t mag;
    cms = (ppc == 8'h0) ? 32'h0 : (32'(cnt) * speed_case_pkg::GATES_PER_S) / 32'(ppc);
    // [RULE4] Saturate magnitude at the measurable maximum.
    if (cms > speed_case_pkg::MAX_SPEED_CMS) cms = speed_case_pkg::MAX_SPEED_CMS;
    // [RULE3] Slow speeds read as zero.
    if (cms < speed_case_pkg::MIN_SPEED_CMS) cms = 32'h0;
    mag = speed_t'(cms[SW-1:0]);
    to_speed = rev ? -mag : mag;
  endfunction

  wire speed_t spd_first_next = to_speed(cnt_first_reg, ppc_first_i, wheel_pulse_first_dir_i);
  wire speed_t spd_second_next = to_speed(cnt_second_reg, ppc_second_i, wheel_pulse_second_dir_i);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      spd_first_reg <= '0;
      spd_second_reg <= '0;
      dir_first_reg <= 1'b0;
      dir_second_reg <= 1'b0;
    end else if (gate_end) begin
      spd_first_reg <= spd_first_next;
      spd_second_reg <= spd_second_next;
      dir_first_reg <= spd_first_next < 0;
      dir_second_reg <= spd_second_next < 0;
    end
  end

  // Magnitude of a signed speed, used by the selection and by the checks.
  function automatic logic [SW-1:0] mag_of(input speed_t s);
    mag_of = s < 0 ? SW'(-s) : SW'(s);
  endfunction

  // Magnitudes and the higher value used for selection.
  wire [SW-1:0] mag_first = mag_of(spd_first_reg);
  wire [SW-1:0] mag_second = mag_of(spd_second_reg);
  // [RULE7] Higher of the two speeds.
  wire speed_t eval_speed = mag_first >= mag_second ? spd_first_reg : spd_second_reg;
  wire [SW-1:0] mag_hi = mag_first >= mag_second ? mag_first : mag_second;
  wire [SW-1:0] mag_lo = mag_first >= mag_second ? mag_second : mag_first;
  // [RULE5] Difference as percent of the higher speed.
  wire [31:0] diff_scaled = 32'(mag_hi - mag_lo) * 32'd100;
  wire [31:0] limit_scaled = 32'(mag_hi) * 32'(diff_pct_i);
  wire diff_over = diff_scaled > limit_scaled;
  wire opposite = (spd_first_reg != 0) && (spd_second_reg != 0) && (dir_first_reg != dir_second_reg);

  // Case match: input A pattern plus speed range where enabled.
  wire [NUM_CASES-1:0] match;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CASES; gi++) begin : g_case
      wire speed_t lo = speed_t'(case_min_i[gi*SW +: SW]);
      wire speed_t hi = speed_t'(case_max_i[gi*SW +: SW]);
      // [RULE8] Range check for speed-enabled cases.
      wire in_rng = (eval_speed >= lo) && (eval_speed <= hi);
      // [RULE16] A case with range disabled ignores wheel data.
      assign match[gi] = case_valid_i[gi] && (case_in_a_i[gi] == gen_in_i[0])
                         && (!case_use_speed_i[gi] || !inc_enable_i || in_rng);
    end
  endgenerate

  // [RULE10] Keep the two lowest-numbered matches only.
  function automatic logic [NUM_CASES-1:0] first_two(input logic [NUM_CASES-1:0] m);
    logic [NUM_CASES-1:0] r;
    int unsigned n;
    r = '0;
    n = 0;
    for (int i = 0; i < NUM_CASES; i++) begin
      if (m[i] && n < 2) begin
        r[i] = 1'b1;
        n++;
      end
    end
    first_two = r;
  endfunction

  wire [NUM_CASES-1:0] active_next = first_two(match);
  wire ignore_speed = |(active_next & ~case_use_speed_i);
  // [RULE12] Field state of each active case routed to its output.
  wire trip_a = |(active_next & ~case_out_b_i & ~field_clear_i);
  wire trip_b = |(active_next & case_out_b_i & ~field_clear_i);

  logic [15:0] diff_gates_reg;
  logic fault_reg;
  // [RULE6] Disagreement timed in gates; fault past the hold time.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      diff_gates_reg <= 16'h0;
    end else if (gate_tick_reg) begin
      // The count saturates so that a very long disagreement never wraps back to no fault.
      diff_gates_reg <= (diff_over && inc_enable_i) ?
                        (diff_gates_reg == 16'hffff ? diff_gates_reg : diff_gates_reg + 16'h1) : 16'h0;
    end
  end
  wire diff_timeout = diff_gates_reg > speed_case_pkg::DIFF_HOLD_GATES;
  // [RULE15] Opposite directions shut down unless speed is ignored.
  wire dir_fault = inc_enable_i && opposite && !ignore_speed;
  // [RULE17] No case, overlong disagreement or no scanner is an error.
  // [RULE14] A missing scanner configuration is refused as an error.
  wire fault_now = (active_next == '0) || (diff_timeout && !ignore_speed) || dir_fault
                   || (sensors_present_i == 2'b00);

  // [RULE13] Restart counters per output; delayed restart waits after the field clears.
  logic [15:0] rst_a_reg, rst_b_reg;
  wire [15:0] rs_gates = 16'(speed_case_pkg::RESTART_GATES);
  wire hold_a = trip_a || fault_now;
  wire hold_b = trip_b || fault_now;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_a_reg <= 16'h0;
      rst_b_reg <= 16'h0;
    end else begin
      rst_a_reg <= hold_a ? rs_gates : (gate_tick_reg && rst_a_reg != 0 ? rst_a_reg - 16'h1 : rst_a_reg);
      rst_b_reg <= hold_b ? rs_gates : (gate_tick_reg && rst_b_reg != 0 ? rst_b_reg - 16'h1 : rst_b_reg);
    end
  end
  wire on_a = !hold_a && (!restart_delayed_i[0] || rst_a_reg == 0);
  wire on_b = !hold_b && (!restart_delayed_i[1] || rst_b_reg == 0);

  // Registered outputs.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gen_in_o <= 2'b00;
      speed_o <= '0;
      case_active_o <= '0;
      safety_output_a_o <= 1'b0;
      safety_output_b_o <= 1'b0;
      diff_flag_o <= 1'b0;
      error_o <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      gen_in_o <= gen_in_i[1:0];
      speed_o <= eval_speed;
      case_active_o <= active_next;
      safety_output_a_o <= on_a;
      safety_output_b_o <= on_b;
      diff_flag_o <= diff_over && inc_enable_i;
      error_o <= fault_now;
      fault_reg <= fault_now;
    end
  end

  // [RULE10] Two cases at most.
  chk_at_most_two: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE10]
    $countones(case_active_o) <= 2) else $error("more than two cases active");
  // [RULE17] Error forces outputs off.
  chk_error_outputs_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE17]
    fault_reg |-> !safety_output_a_o && !safety_output_b_o) else $error("output on during error");
  // [RULE3] Dead band reads zero.
  chk_slow_is_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE3]
    speed_o == 0 || speed_o >= 10 || speed_o <= -10) else $error("speed inside dead band");
  // [RULE4] Speed stays in range.
  chk_speed_limit: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE4]
    speed_o <= 2000 && speed_o >= -2000) else $error("speed beyond range");
  // [RULE15] Direction mismatch shuts down.
  chk_dir_shutdown: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE15]
    dir_fault |=> error_o && !safety_output_a_o) else $error("direction mismatch not shut down");
  // [RULE1] Pins ignored when off.
  // A pulse taken while sensing was still on may land one edge after it goes off, so the previous enable is used.
  chk_pins_reserved: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE1]
    !$past(inc_enable_i) |-> $past(gate_end) || ($stable(cnt_first_reg) && $stable(cnt_second_reg)))
    else $error("pulse counted");
  // [RULE13] Delayed restart holds off.
  chk_delayed_restart: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE13]
    restart_delayed_i[0] && rst_a_reg != 0 |=> !safety_output_a_o) else $error("restart too early");
  // [RULE7] Output speed is higher.
  chk_higher_speed: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE7]
    1'b1 |=> mag_of(speed_o) >= $past(mag_first) && mag_of(speed_o) >= $past(mag_second))
    else $error("lower speed selected");
  cov_two_active: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) $countones(case_active_o) == 2);
  cov_diff: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) diff_flag_o);
  cov_error: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) $rose(error_o));
  cov_restart_wait: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    restart_delayed_i[0] && !hold_a && rst_a_reg != 0);
endmodule // speed_case_selector
`default_nettype wire

// ==== inc/speed_case_pkg.sv ====
// Constants for the speed based field case selector.
// Assumes a single 20 MHz system clock; configuration arrives as plain ports.
// Operation
// [RULE1] With speed sensing on, general inputs C and D carry wheel pulses and read as zero to ordinary logic.
// [RULE2] Each wheel channel converts its pulse count to cm/s with its own pulses-per-cm setting.
// [RULE3] Any speed whose magnitude is under 10 cm/s is taken as exactly 0 cm/s.
// [RULE4] Speed is signed and covers magnitudes up to 2000 cm/s, saturating beyond.
// [RULE5] The two speeds are compared against a configurable percentage limit, 25 % recommended.
// [RULE6] Disagreement beyond the limit is tolerated for at most 20 seconds, then it is a fault.
// [RULE7] Case selection uses the higher of the two speeds.
// [RULE8] A case with its speed range enabled is active only while the speed lies within its bounds; the code skips the check while speed sensing is off.
// [RULE9] The configuring party sets bounds outside the band from -10 to +10 cm/s, lower bound negative.
// [RULE10] At most two cases are active at once.
// [RULE11] The configuring party covers every reachable speed with some case.
// [RULE12] Each active case routes its chosen sensor field to its chosen safety output.
// [RULE13] Each safety output has a selectable restart: immediate or delayed, default two seconds.
// [RULE14] At least one scanner sensor must be configured.
// [RULE15] Opposite directions on the two wheels shut down, unless an active case ignores speed.
// [RULE16] A case with its speed range disabled ignores wheel data, including direction mismatch.
// [RULE17] No matching case or an overlong disagreement drives the safety outputs off and flags an error.
`default_nettype none
package speed_case_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned GATE_MS = 100;
  localparam int unsigned GATE_CYC = CLK_HZ / 1000 * GATE_MS;
  localparam int unsigned GATES_PER_S = 1000 / GATE_MS;
  localparam int unsigned MIN_SPEED_CMS = 10;
  localparam int unsigned MAX_SPEED_CMS = 2000;
  localparam int unsigned DIFF_PCT_RESET = 25;
  localparam int unsigned DIFF_HOLD_S = 20;
  localparam int unsigned DIFF_HOLD_GATES = DIFF_HOLD_S * GATES_PER_S;
  localparam int unsigned RESTART_DELAY_S = 2;
  localparam int unsigned RESTART_GATES = RESTART_DELAY_S * GATES_PER_S;
  localparam int unsigned SPEED_W = 12;
  localparam int unsigned PPC_W = 8;
  localparam int unsigned NUM_CASES = 8;
  localparam int unsigned CASE_IDX_W = 3;
endpackage
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the speed case selector.
// Assumes a 200-cycle gate. Wheel 1 runs at 1 pulse/cm, so speed is 2000/period cm/s.
// Wheel 2 runs at 2 pulses/cm, so speed is 1000/period cm/s.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [15:0] per1 = 16'h0000;
  logic [15:0] per2 = 16'h0000;
  wire [3:0] gen_in;
  logic [1:0] gen_ab = 2'h0;
  logic dir1 = 1'b0;
  logic dir2 = 1'b0;
  logic [7:0] valid = 8'h00;
  logic [7:0] use_spd = 8'h00;
  logic [7:0] in_a = 8'h00;
  logic [7:0] outb = 8'h00;
  logic [7:0] clear = 8'hff;
  logic [95:0] cmin = '0;
  logic [95:0] cmax = '0;
  logic [1:0] rdly = 2'h0;
  logic inc_en = 1'b1;
  logic [1:0] sens = 2'h1;
  logic [1:0] gen_o;
  logic signed [11:0] speed;
  logic [7:0] active;
  logic out_a, out_b, diff, err;
  int err_total = 0;
  int samples_checked = 0;

  // The clock inverts every half period of 25 ns.
  always #25 clk_sys_i = ~clk_sys_i;
  assign gen_in[1:0] = gen_ab;
  wheel_pulse_model wheel_first_i (.clk_sys_i(clk_sys_i), .period_i(per1), .pulse_o(gen_in[2]));
  wheel_pulse_model wheel_second_i (.clk_sys_i(clk_sys_i), .period_i(per2), .pulse_o(gen_in[3]));
  speed_case_selector #(.NUM_CASES(8), .GATE_CYC(200)) speed_case_selector_i (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .inc_enable_i(inc_en), .gen_in_i(gen_in),
    .wheel_pulse_first_dir_i(dir1), .wheel_pulse_second_dir_i(dir2), .ppc_first_i(8'h01),
    .ppc_second_i(8'h02), .diff_pct_i(7'h19), .case_valid_i(valid), .case_use_speed_i(use_spd),
    .case_in_a_i(in_a), .case_min_i(cmin), .case_max_i(cmax), .case_out_b_i(outb),
    .field_clear_i(clear), .restart_delayed_i(rdly), .sensors_present_i(sens), .gen_in_o(gen_o),
    .speed_o(speed), .case_active_o(active), .safety_output_a_o(out_a), .safety_output_b_o(out_b),
    .diff_flag_o(diff), .error_o(err));

  // Compares one speed result and counts it. A mismatch is reported at once.
  task automatic chk_speed(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compares one case or pin vector and counts it.
  task automatic chk_cases(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compares one flag and counts it; an unknown level counts as a mismatch.
  task automatic chk_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Waits whole gates on the falling edge, where the bench drives.
  task automatic gates(input int n);
    repeat (n * 200) @(negedge clk_sys_i);
  endtask

  // Sets both wheel periods, then lets a full gate and the answer latency pass.
  task automatic run(input logic [15:0] p1, input logic [15:0] p2, input int n);
    per1 <= p1;
    per2 <= p2;
    gates(n);
  endtask

  // Sets up one case. Speed-enabled cases get bounds outside the band from -10 to +10 cm/s.
  task automatic set_case(input int i, input logic [11:0] mn, input logic [11:0] mx, input logic b,
                          input logic a, input logic s);
    valid[i] <= 1'b1;
    cmin[12*i+:12] <= mn;
    cmax[12*i+:12] <= mx;
    outb[i] <= b;
    in_a[i] <= a;
    use_spd[i] <= s;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Runs the test sequence.
  initial begin
    repeat (8) @(negedge clk_sys_i);
    chk_cases(active, 8'h00);
    chk_flag(err, 1'b0);
    chk_flag(out_a, 1'b0);
    rst_n_i <= 1'b1;
    set_case(0, -12'sd30, 12'sd30, 1'b0, 1'b0, 1'b1);
    set_case(1, -12'sd30, 12'sd30, 1'b1, 1'b0, 1'b1);
    set_case(2, 12'sd30, 12'sd300, 1'b0, 1'b0, 1'b1);
    set_case(3, 12'sd0, 12'sd0, 1'b0, 1'b1, 1'b0);
    set_case(4, -12'sd30, 12'sd30, 1'b1, 1'b0, 1'b1);
    gen_ab <= 2'h2;
    run(16'h0000, 16'h00c8, 3);
    chk_cases({6'h00, gen_o}, 8'h02);
    chk_speed(speed, 12'h000);
    chk_cases(active, 8'h03);
    chk_flag(out_b, 1'b1);
    $display("test slow cases done");
    run(16'h000a, 16'h0005, 3);
    chk_speed(speed, 12'd200);
    chk_cases(active, 8'h04);
    chk_flag(out_a, 1'b1);
    clear[2] <= 1'b0;
    gates(1);
    chk_flag(out_a, 1'b0);
    clear <= 8'hff;
    run(16'h0008, 16'h0005, 3);
    chk_speed(speed, 12'd250);
    chk_flag(diff, 1'b0);
    $display("test speed done");
    dir2 <= 1'b1;
    run(16'h000a, 16'h0005, 3);
    chk_flag(out_a, 1'b0);
    chk_flag(err, 1'b1);
    gen_ab <= 2'h1;
    gates(3);
    chk_cases(active, 8'h08);
    chk_flag(out_a, 1'b1);
    dir2 <= 1'b0;
    gen_ab <= 2'h0;
    run(16'h0004, 16'h0002, 3);
    chk_speed(speed, 12'd500);
    chk_flag(err, 1'b1);
    chk_flag(out_a, 1'b0);
    $display("test direction and no match done");
    run(16'h000a, 16'h0005, 3);
    rdly <= 2'h1;
    clear[2] <= 1'b0;
    gates(2);
    clear <= 8'hff;
    gates(15);
    chk_flag(out_a, 1'b0);
    gates(10);
    chk_flag(out_a, 1'b1);
    $display("test restart done");
    rdly <= 2'h0;
    run(16'h0008, 16'h000a, 3);
    chk_flag(diff, 1'b1);
    gates(190);
    chk_flag(err, 1'b0);
    gates(15);
    chk_flag(err, 1'b1);
    chk_flag(out_a, 1'b0);
    $display("test disagreement done");
    inc_en <= 1'b0;
    gates(3);
    chk_speed(speed, 12'h000);
    chk_cases(active, 8'h03);
    chk_flag(err, 1'b0);
    sens <= 2'h0;
    gates(1);
    chk_flag(err, 1'b1);
    chk_flag(out_a, 1'b0);
    $display("test sensing off and no scanner done");
    test_done();
  end
endmodule // testbench
`default_nettype wire

// ==== verification/wheel_pulse_model.sv ====
// Model of one incremental wheel sensor that feeds one pulse input.
// Assumes the bench gives the pulse period in clock cycles. A period of zero stops the wheel.
`default_nettype none
module wheel_pulse_model (
  input wire logic clk_sys_i,
  input wire logic [15:0] period_i,
  output var logic pulse_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_reg = 16'h0000;
  initial pulse_o = 1'b0;
  // Gives one high cycle per period. It changes on the falling edge, away from the sampling edge.
  always @(negedge clk_sys_i) begin
    cnt_reg <= (cnt_reg + 16'h0001 >= period_i) ? 16'h0000 : cnt_reg + 16'h0001;
    pulse_o <= (period_i != 16'h0000) && (cnt_reg == 16'h0000);
  end
endmodule // wheel_pulse_model
`default_nettype wire
